// file: dac_ctrl_device.sv
`timescale 1ns/1ps
module dac_ctrl_device
#(
    parameter logic [5:0] DEV_ADDR = dac_ctrl_pkg::DEV_ADDR_DEFAULT
)
(
    // System
    input wire logic clk,
    input wire logic srst,
    // Serial link
    ctrl_link_if.device link,
    // Settings
    output dac_ctrl_pkg::clock_ratio_e clock_ratio,
    output dac_ctrl_pkg::input_format_e input_format,
    output logic [5:0] volume_code,
    output logic [5:0] atten_db,
    output logic atten_full,
    output dac_ctrl_pkg::deemph_e deemph_sel,
    output logic soft_mute_flag,
    output logic selected
);
    import dac_ctrl_pkg::*;

    // Link side: byte assembly
    typedef struct packed {
        logic rst_m;
        logic rst_s;
        logic mode;
        logic [2:0] cnt;
        logic [6:0] sr;
        logic [7:0] hold_byte;
        logic hold_addr;
        logic tgl;
    } link_s;

    // System side: decode and settings
    typedef struct packed {
        logic t_m;
        logic t_s;
        logic t_p;
        logic sel;
        logic [1:0] xtype;
        clock_ratio_e ratio;
        input_format_e fmt;
        logic [5:0] vol;
        logic [5:0] atten;
        logic full;
        deemph_e deemph;
        logic mute;
    } sys_s;

    // Power-up value: the link clock may give no edge at all while srst is high
    link_s l_q = '0;
    link_s l_d;
    sys_s s_q;
    sys_s s_d;
    logic [7:0] nb;

    // Shift bits in on rising link clock; a strobe change restarts the byte
    always_comb
    begin
        l_d = l_q;
        l_d.rst_m = srst;
        l_d.rst_s = l_q.rst_m;
        // Synced reset only clears framing outside address bytes: the link clock stops
        // once reset ends, so the synchroniser may still read high over the first one.
        // Hand-over fields keep their value so no stray toggle reaches the decoder.
        if (l_q.rst_s && !link.ctrl_address_strobe)
        begin
            l_d.mode = 1'b0;
            l_d.cnt = 3'h0;
            l_d.sr = 7'h00;
        end
        else if (link.ctrl_address_strobe != l_q.mode)
        begin
            // Partial byte of the other kind is dropped
            l_d.mode = link.ctrl_address_strobe;
            l_d.cnt = 3'h1;
            l_d.sr = {6'h00, link.ctrl_serial_data};
        end
        else
        begin
            l_d.cnt = l_q.cnt + 3'h1;
            l_d.sr = {l_q.sr[5:0], link.ctrl_serial_data};
            if (l_q.cnt == 3'(BYTE_BITS - 1))
            begin
                // Complete byte handed across with a toggle
                l_d.hold_byte = {l_q.sr, link.ctrl_serial_data};
                l_d.hold_addr = l_q.mode;
                l_d.tgl = ~l_q.tgl;
            end
        end
    end

    always_ff @(posedge link.ctrl_serial_clock)
    begin
        l_q <= l_d;
    end

    assign nb = l_q.hold_byte;

    // Decode each new byte into the setting registers
    always_comb
    begin
        s_d = s_q;
        s_d.t_m = l_q.tgl;
        s_d.t_s = s_q.t_m;
        s_d.t_p = s_q.t_s;
        if (srst)
        begin
            s_d.sel = 1'b0;
            s_d.xtype = XFER_DATA;
            s_d.ratio = clock_ratio_e'(RST_RATIO);
            s_d.fmt = input_format_e'(RST_FORMAT);
            s_d.vol = RST_VOLUME;
            s_d.atten = 6'h00;
            s_d.full = 1'b0;
            s_d.deemph = deemph_e'(RST_DEEMPH);
            s_d.mute = RST_MUTE;
        end
        else if (s_q.t_s != s_q.t_p)
        begin
            if (l_q.hold_addr)
            begin
                // Address byte: match and type stay until the next one
                s_d.sel = (nb[ADDR_MSB:ADDR_LSB] == DEV_ADDR);
                s_d.xtype = nb[TYPE_MSB:TYPE_LSB];
            end
            else if (s_q.sel && s_q.xtype == XFER_STATUS)
            begin
                if (nb[PFX_MSB:PFX_LSB] == PFX_RATIO_FORMAT && !nb[0]
                    && nb[RATIO_MSB:RATIO_LSB] != RATIO_UNUSED
                    && nb[FMT_MSB:FMT_LSB] <= FMT_MSBJ)
                begin
                    s_d.ratio = clock_ratio_e'(nb[RATIO_MSB:RATIO_LSB]);
                    s_d.fmt = input_format_e'(nb[FMT_MSB:FMT_LSB]);
                end
            end
            else if (s_q.sel && s_q.xtype == XFER_DATA)
            begin
                if (nb[PFX_MSB:PFX_LSB] == PFX_VOLUME)
                begin
                    s_d.vol = nb[VAL_MSB:0];
                    // Codes 0 and 1 are 0 dB, then 1 dB a step up to 60 dB at code 61 and held there, 63 full
                    s_d.full = (nb[VAL_MSB:0] == VOL_FULL_CODE);
                    if (nb[VAL_MSB:1] == 5'h00)
                    begin
                        s_d.atten = 6'h00;
                    end
                    else if (nb[VAL_MSB:0] - 6'h01 > ATTEN_MAX_DB)
                    begin
                        s_d.atten = ATTEN_MAX_DB;
                    end
                    else
                    begin
                        s_d.atten = nb[VAL_MSB:0] - 6'h01;
                    end
                end
                else if (nb[PFX_MSB:PFX_LSB] == PFX_DEEMPH_MUTE
                    && !nb[VAL_MSB] && nb[1:0] == 2'b00)
                begin
                    s_d.deemph = deemph_e'(nb[DEEMPH_MSB:DEEMPH_LSB]);
                    s_d.mute = nb[MUTE_POS];
                end
                else if (nb[PFX_MSB:PFX_LSB] == PFX_DEFAULTS
                    && nb[VAL_MSB:0] == DEFAULTS_CMD)
                begin
                    s_d.ratio = clock_ratio_e'(RST_RATIO);
                    s_d.fmt = input_format_e'(RST_FORMAT);
                    s_d.vol = RST_VOLUME;
                    s_d.atten = 6'h00;
                    s_d.full = 1'b0;
                    s_d.deemph = deemph_e'(RST_DEEMPH);
                    s_d.mute = RST_MUTE;
                end
                // Prefix 01 and other codes fall through unchanged
            end
            // Unused transfer types or deselected device: nothing stored
        end
    end

    always_ff @(posedge clk)
    begin
        s_q <= s_d;
    end

    // Registered setting outputs
    assign clock_ratio = s_q.ratio;
    assign input_format = s_q.fmt;
    assign volume_code = s_q.vol;
    assign atten_db = s_q.atten;
    assign atten_full = s_q.full;
    assign deemph_sel = s_q.deemph;
    assign soft_mute_flag = s_q.mute;
    assign selected = s_q.sel;

endmodule : dac_ctrl_device

// file: dac_ctrl_pkg.sv
package dac_ctrl_pkg;

    // Serial byte framing
    localparam int BYTE_BITS = 8;
    localparam int ADDR_MSB = 7;
    localparam int ADDR_LSB = 2;
    localparam int TYPE_MSB = 1;
    localparam int TYPE_LSB = 0;
    localparam int PFX_MSB = 7;
    localparam int PFX_LSB = 6;
    localparam int VAL_MSB = 5;

    // Device address answered by the device end (value is arbitrary)
    localparam logic [5:0] DEV_ADDR_DEFAULT = 6'h2A;

    // Transfer type codes in the address byte
    localparam logic [1:0] XFER_DATA = 2'h0;
    localparam logic [1:0] XFER_STATUS = 2'h2;

    // Register prefixes in data bytes
    localparam logic [1:0] PFX_VOLUME = 2'h0;
    localparam logic [1:0] PFX_DEEMPH_MUTE = 2'h2;
    localparam logic [1:0] PFX_DEFAULTS = 2'h3;
    localparam logic [1:0] PFX_RATIO_FORMAT = 2'h0;
    localparam logic [5:0] DEFAULTS_CMD = 6'h01;

    // Field positions inside the 6-bit value
    localparam int RATIO_MSB = 5;
    localparam int RATIO_LSB = 4;
    localparam int FMT_MSB = 3;
    localparam int FMT_LSB = 1;
    localparam int DEEMPH_MSB = 4;
    localparam int DEEMPH_LSB = 3;
    localparam int MUTE_POS = 2;

    // System clock ratio codes
    typedef enum logic [1:0] {
        RATIO_512FS = 2'b00,
        RATIO_384FS = 2'b01,
        RATIO_256FS = 2'b10,
        RATIO_UNUSED = 2'b11
    } clock_ratio_e;

    // Input format codes
    typedef enum logic [2:0] {
        FMT_I2S = 3'b000,
        FMT_LSBJ16 = 3'b001,
        FMT_LSBJ18 = 3'b010,
        FMT_LSBJ20 = 3'b011,
        FMT_MSBJ = 3'b100
    } input_format_e;

    // De-emphasis codes
    typedef enum logic [1:0] {
        DEEMPH_OFF = 2'b00,
        DEEMPH_32K = 2'b01,
        DEEMPH_44K1 = 2'b10,
        DEEMPH_48K = 2'b11
    } deemph_e;

    // Reset and default settings
    localparam logic [5:0] RST_VOLUME = 6'h00;
    localparam logic [1:0] RST_DEEMPH = 2'h0;
    localparam logic RST_MUTE = 1'b0;
    localparam logic [2:0] RST_FORMAT = 3'h0;
    localparam logic [1:0] RST_RATIO = 2'h2;

    // Volume code mapping
    localparam logic [5:0] VOL_FULL_CODE = 6'h3F;
    localparam logic [5:0] ATTEN_MAX_DB = 6'h3C;

    // Link clock timing on the host side
    localparam int CLK_PERIOD_NS = 20;
    localparam int LINK_HALF_NS = 160;
    localparam int LINK_HALF_CYC = (LINK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] LINK_HALF_CNT = 4'(LINK_HALF_CYC - 1);

endpackage : dac_ctrl_pkg

// file: ctrl_link_if.sv
`timescale 1ns/1ps
interface ctrl_link_if;
    logic ctrl_serial_clock;
    logic ctrl_address_strobe;
    logic ctrl_serial_data;

    // Microcontroller end drives all three lines
    modport host (
        output ctrl_serial_clock,
        output ctrl_address_strobe,
        output ctrl_serial_data
    );

    // DAC end only listens
    modport device (
        input ctrl_serial_clock,
        input ctrl_address_strobe,
        input ctrl_serial_data
    );
endinterface : ctrl_link_if

// file: dac_ctrl_host.sv
`timescale 1ns/1ps
module dac_ctrl_host
(
    // System
    input wire logic clk,
    input wire logic srst,
    // Byte request
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic cmd_is_addr,
    input wire logic [7:0] cmd_byte,
    // Serial link
    ctrl_link_if.host link
);
    import dac_ctrl_pkg::*;

    typedef enum logic [1:0] {
        H_IDLE = 2'b00,
        H_LOW = 2'b01,
        H_HIGH = 2'b10
    } host_state_e;

    typedef struct packed {
        host_state_e st;
        logic [3:0] div;
        logic [2:0] bits;
        logic [7:0] sr;
        logic sclk;
        logic strobe;
        logic sdata;
    } host_s;

    host_s s_q;
    host_s s_d;

    // Byte shifter: data changes with the clock low, device samples on the rise
    always_comb
    begin
        s_d = s_q;
        if (srst)
        begin
            s_d.st = H_IDLE;
            s_d.bits = 3'h0;
            s_d.sr = 8'h00;
            s_d.strobe = 1'b0;
            s_d.sdata = 1'b0;
            // Clock keeps running in reset so the far end can reset too;
            // the first reset cycle, or one cut into a byte, reloads the divider
            if (s_q.st == H_IDLE)
            begin
                if (s_q.div == 4'h0)
                begin
                    s_d.div = LINK_HALF_CNT;
                    s_d.sclk = ~s_q.sclk;
                end
                else
                begin
                    s_d.div = s_q.div - 4'h1;
                end
            end
            else
            begin
                s_d.div = LINK_HALF_CNT;
                s_d.sclk = 1'b0;
            end
        end
        else
        begin
            case (s_q.st)
                H_IDLE:
                begin
                    s_d.sclk = 1'b0;
                    if (cmd_valid)
                    begin
                        // Address bytes carry device address then type, MSB first
                        s_d.strobe = cmd_is_addr;
                        s_d.sdata = cmd_byte[7];
                        s_d.sr = {cmd_byte[6:0], 1'b0};
                        s_d.bits = 3'h7;
                        s_d.div = LINK_HALF_CNT;
                        s_d.st = H_LOW;
                    end
                end
                H_LOW:
                begin
                    if (s_q.div == 4'h0)
                    begin
                        s_d.sclk = 1'b1;
                        s_d.div = LINK_HALF_CNT;
                        s_d.st = H_HIGH;
                    end
                    else
                    begin
                        s_d.div = s_q.div - 4'h1;
                    end
                end
                H_HIGH:
                begin
                    if (s_q.div == 4'h0)
                    begin
                        s_d.sclk = 1'b0;
                        s_d.div = LINK_HALF_CNT;
                        if (s_q.bits == 3'h0)
                        begin
                            // Whole byte sent; clock stays low between bytes
                            s_d.st = H_IDLE;
                        end
                        else
                        begin
                            s_d.sdata = s_q.sr[7];
                            s_d.sr = {s_q.sr[6:0], 1'b0};
                            s_d.bits = s_q.bits - 3'h1;
                            s_d.st = H_LOW;
                        end
                    end
                    else
                    begin
                        s_d.div = s_q.div - 4'h1;
                    end
                end
                default:
                begin
                    s_d.st = H_IDLE;
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge clk)
    begin
        s_q <= s_d;
    end

    // Outputs
    assign cmd_ready = (s_q.st == H_IDLE) && !srst;
    assign link.ctrl_serial_clock = s_q.sclk;
    assign link.ctrl_address_strobe = s_q.strobe;
    assign link.ctrl_serial_data = s_q.sdata;

endmodule : dac_ctrl_host

// file: dac_link_chk.sv
`timescale 1ns/1ps
module dac_link_chk
(
    // System
    input wire logic clk,
    input wire logic srst,
    // Link lines
    input wire logic ctrl_serial_clock,
    input wire logic ctrl_address_strobe,
    input wire logic ctrl_serial_data
);
    logic sclk_q;
    logic [3:0] rise_q;
    logic [4:0] low_q;

    // Count rising link edges per byte; a long low run ends the byte
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            sclk_q <= 1'b1;
            rise_q <= 4'h0;
            low_q <= 5'h00;
        end
        else
        begin
            sclk_q <= ctrl_serial_clock;
            low_q <= ctrl_serial_clock ? 5'h00 : ((low_q == 5'h1F) ? low_q : low_q + 5'h01);
            if (ctrl_serial_clock && !sclk_q)
                rise_q <= rise_q + 4'h1;
            else if (low_q > 5'h08)
                rise_q <= 4'h0;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    property p_strobe_between_bytes;
        $changed(ctrl_address_strobe) |-> !ctrl_serial_clock && (rise_q == 4'h0 || rise_q == 4'h8);
    endproperty
    a_strobe_between_bytes: assert property (p_strobe_between_bytes)
        else $error("strobe changed inside a byte");
    property p_data_when_low;
        $changed(ctrl_serial_data) |-> !ctrl_serial_clock;
    endproperty
    a_data_when_low: assert property (p_data_when_low)
        else $error("data changed while link clock high");
    property p_high_phase;
        $rose(ctrl_serial_clock) && !$past(srst) |-> ctrl_serial_clock [*8] ##1 !ctrl_serial_clock;
    endproperty
    a_high_phase: assert property (p_high_phase)
        else $error("link clock high phase wrong length");
    property p_low_phase;
        $fell(ctrl_serial_clock) && !$past(srst) |-> !ctrl_serial_clock [*8];
    endproperty
    a_low_phase: assert property (p_low_phase)
        else $error("link clock low phase too short");
    property p_bits_per_byte;
        low_q == 5'h09 |-> rise_q == 4'h0 || rise_q == 4'h8;
    endproperty
    a_bits_per_byte: assert property (p_bits_per_byte)
        else $error("byte without eight clock edges");
    property p_first_bit_setup;
        $rose(ctrl_address_strobe) |-> !ctrl_serial_clock [*8] ##1 ctrl_serial_clock;
    endproperty
    a_first_bit_setup: assert property (p_first_bit_setup)
        else $error("address byte first edge misplaced");
    property p_rise_stable;
        $rose(ctrl_serial_clock) |-> $stable(ctrl_address_strobe) && $stable(ctrl_serial_data);
    endproperty
    a_rise_stable: assert property (p_rise_stable)
        else $error("lines moved at link clock rise");
    property p_idle_after_reset;
        $fell(srst) |=> !ctrl_serial_clock [*8];
    endproperty
    a_idle_after_reset: assert property (p_idle_after_reset)
        else $error("link clock not idle after reset");

    // Main traffic kinds
    c_addr_byte: cover property ($rose(ctrl_address_strobe));
    c_data_byte: cover property ($fell(ctrl_address_strobe));
    c_full_byte: cover property (low_q == 5'h09 && rise_q == 4'h8);
endmodule : dac_link_chk

// file: testbench.sv
`timescale 1ns/1ps
module testbench;
    import dac_ctrl_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic cmd_valid = 1'b0;
    logic cmd_ready;
    logic cmd_is_addr = 1'b0;
    logic [7:0] cmd_byte = 8'h00;
    clock_ratio_e clock_ratio;
    input_format_e input_format;
    logic [5:0] volume_code;
    logic [5:0] atten_db;
    logic atten_full;
    deemph_e deemph_sel;
    logic soft_mute_flag;
    logic selected;
    logic [1:0] er = RST_RATIO;
    logic [2:0] ef = RST_FORMAT;
    logic [5:0] ev = RST_VOLUME;
    logic [1:0] ed = RST_DEEMPH;
    logic em = RST_MUTE;
    int fail_count = 0;
    int samples_checked = 0;
    logic [7:0] bad_status [4] = '{8'h38, 8'h2A, 8'h29, 8'h80};
    logic [7:0] bad_data [4] = '{8'h40, 8'hC2, 8'hA0, 8'h81};
    logic [5:0] vols [6] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h20, 6'h3F};

    ctrl_link_if lk();
    dac_ctrl_host dac_ctrl_host_i (.clk(clk), .srst(srst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_is_addr(cmd_is_addr), .cmd_byte(cmd_byte), .link(lk));
    dac_ctrl_device dac_ctrl_device_i (.clk(clk), .srst(srst), .link(lk), .clock_ratio(clock_ratio),
        .input_format(input_format), .volume_code(volume_code), .atten_db(atten_db), .atten_full(atten_full),
        .deemph_sel(deemph_sel), .soft_mute_flag(soft_mute_flag), .selected(selected));
    dac_link_chk dac_link_chk_i (.clk(clk), .srst(srst), .ctrl_serial_clock(lk.ctrl_serial_clock),
        .ctrl_address_strobe(lk.ctrl_address_strobe), .ctrl_serial_data(lk.ctrl_serial_data));

    // System clock
    always #10 clk = ~clk;

    task end_of_test;
        $display("checked %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_of_test

    task chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // Compare every setting output except selected with the expected settings
    task check_all;
        chk(8'(clock_ratio), 8'(er));
        chk(8'(input_format), 8'(ef));
        chk(8'(volume_code), 8'(ev));
        chk(8'(atten_db), (ev < 6'h02) ? 8'h00 : ((ev > 6'h3C) ? 8'h3C : 8'(ev - 6'h01)));
        chk(8'(atten_full), 8'(ev == 6'h3F));
        chk(8'(deemph_sel), 8'(ed));
        chk(8'(soft_mute_flag), 8'(em));
    endtask : check_all

    // One byte through the host request handshake
    task send(input logic a, input logic [7:0] b);
        int n;
        n = 0;
        cmd_is_addr = a;
        cmd_byte = b;
        cmd_valid = 1'b1;
        while (cmd_ready !== 1'b1 && n < 300)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        @(posedge clk);
        #1;
        cmd_valid = 1'b0;
        while (cmd_ready !== 1'b1 && n < 600)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n >= 300)
        begin
            fail_count++;
            end_of_test();
        end
        repeat (4) @(posedge clk);
        #1;
    endtask : send

    initial
    begin
        repeat (10) @(posedge clk);
        #1;
        srst = 1'b0;
        check_all();
        chk(8'(selected), 8'h00);
        $display("test reset done");
        send(1'b1, {DEV_ADDR_DEFAULT, XFER_STATUS});
        chk(8'(selected), 8'h01);
        for (int i = 0; i < 5; i++)
        begin
            er = 2'(i % 3);
            ef = 3'(i);
            send(1'b0, {2'h0, er, ef, 1'b0});
            check_all();
        end
        foreach (bad_status[i])
            send(1'b0, bad_status[i]);
        check_all();
        $display("test status done");
        send(1'b1, {DEV_ADDR_DEFAULT, XFER_DATA});
        foreach (vols[i])
        begin
            ev = vols[i];
            send(1'b0, {2'h0, ev});
            check_all();
        end
        for (int i = 0; i < 4; i++)
        begin
            ed = 2'(i);
            em = i[0];
            send(1'b0, {3'h4, ed, em, 2'h0});
            check_all();
        end
        foreach (bad_data[i])
            send(1'b0, bad_data[i]);
        check_all();
        $display("test data done");
        send(1'b0, {PFX_DEFAULTS, DEFAULTS_CMD});
        {er, ef, ev, ed, em} = {RST_RATIO, RST_FORMAT, RST_VOLUME, RST_DEEMPH, RST_MUTE};
        check_all();
        $display("test defaults done");
        send(1'b1, {~DEV_ADDR_DEFAULT, XFER_DATA});
        chk(8'(selected), 8'h00);
        send(1'b0, 8'h05);
        check_all();
        send(1'b1, {DEV_ADDR_DEFAULT, 2'h1});
        send(1'b0, 8'h07);
        send(1'b1, {DEV_ADDR_DEFAULT, 2'h3});
        send(1'b0, 8'h09);
        check_all();
        send(1'b1, {DEV_ADDR_DEFAULT, XFER_DATA});
        ev = 6'h05;
        send(1'b0, 8'h05);
        check_all();
        $display("test address done");
        end_of_test();
    end
endmodule : testbench
